//--- design/uarb_core.v
// Runtime register front end and double-buffered serial engine of the serial port
`timescale 1ns/1ps
`include "uarb_defines.vh"

module uarb_core (
    input  wire        clk,            // System clock, 200 MHz
    input  wire        rst,            // Asynchronous reset, active high
    input  wire        ce,             // Clock enable, freezes all state when low
    input  wire        ec_sel,         // Controller access strobe
    input  wire        ec_wr,          // Controller write, else read
    input  wire [31:0] ec_addr,        // Controller byte address
    input  wire [7:0]  ec_wdata,       // Controller write data
    input  wire        host_sel,       // Host I/O access strobe
    input  wire        host_wr,        // Host write, else read
    input  wire [15:0] host_addr,      // Host I/O address
    input  wire [15:0] host_bar,       // Programmed host I/O base
    input  wire [7:0]  host_wdata,     // Host write data
    input  wire        external_baud_source_select, // Baud clock from external input
    input  wire        slow_clk_tick,  // 1.8432 MHz internal clock (pin domain)
    input  wire        fast_internal_clock, // 24 MHz internal clock (pin domain)
    input  wire        ext_baud_clk,   // External baud clock (pin domain)
    input  wire        rx_pin,         // Serial receive line
    output reg  [7:0]  rdata,          // Read data, one cycle after access
    output reg         rvalid,         // Read data valid pulse
    output reg         tx_pin,         // Serial transmit line
    output reg         rx_ready,       // Receive buffer holds unread byte
    output reg         thr_empty       // Transmit holding buffer empty
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // True when an address falls in the controller window
    function ec_hit;
        input [31:0] a;
        begin
            ec_hit = ((a & `UARB_EC_MASK) == `UARB_EC_BASE);
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] rbr_q;        // receive_buffer
    reg  [7:0] thr_q;        // transmit_holding
    reg  [7:0] div_lo_q;     // baud_divisor_low
    reg  [7:0] div_hi_q;     // baud_divisor_high, bit 7 clock select
    reg  [7:0] ier_q;        // interrupt_enables
    reg  [7:0] fcr_q;        // fifo_control
    reg  [7:0] lcr_q;        // line_control
    reg  [7:0] mcr_q;        // modem_control
    reg  [7:0] scr_q;        // scratch_byte
    reg  [2:0] sy_slow_q, sy_fast_q, sy_ext_q; // Synchronisers plus edge stage
    reg  [1:0] sy_rx_q;      // Receive line synchroniser, level only, no edge stage

    // ------------------------------------------------------------
    // Access arbitration: controller wins when both strike at once
    // ------------------------------------------------------------
    wire       ec_acc   = ec_sel && ec_hit(ec_addr);
    wire       host_acc = host_sel && (host_addr[15:3] == host_bar[15:3]);
    wire       acc      = ec_acc | host_acc;
    wire       wr       = ec_acc ? ec_wr : host_wr;
    wire [2:0] ofs      = ec_acc ? ec_addr[2:0] : host_addr[2:0];
    wire [7:0] wd       = ec_acc ? ec_wdata : host_wdata;
    wire       divisor_latch_select     = lcr_q[`UARB_DIVISOR_LATCH_SELECT_BIT];

    // ------------------------------------------------------------
    // Baud source selection
    // ------------------------------------------------------------
    // Rising edges seen on the synchronised second stage only
    wire slow_edge = sy_slow_q[1] & ~sy_slow_q[2];
    wire fast_edge = sy_fast_q[1] & ~sy_fast_q[2];
    wire ext_edge  = sy_ext_q[1]  & ~sy_ext_q[2];
    wire src_edge  = external_baud_source_select ? ext_edge :
                     (div_hi_q[`UARB_BAUD_SEL_BIT] ? fast_edge : slow_edge);
    wire rx_s      = sy_rx_q[1];

    // Divisor of zero behaves as one so the engine never stalls
    wire [14:0] divisor = {div_hi_q[6:0], div_lo_q};
    reg  [14:0] dcnt_q;
    wire        tick    = src_edge && (dcnt_q <= 15'h0001);                  // 16x tick

    // ------------------------------------------------------------
    // Serial engine state
    // ------------------------------------------------------------
    reg  [7:0] tsr_q;        // Hidden transmit shifter
    reg  [3:0] tbit_q;       // Transmit bit index, 0 start, 1-8 data, 9 stop
    reg  [3:0] tsub_q;       // Transmit 16x phase
    reg        tbusy_q;
    reg  [7:0] rsr_q;        // Hidden receive shifter
    reg  [3:0] rbit_q;
    reg  [3:0] rsub_q;
    reg        rbusy_q;

    // ------------------------------------------------------------
    // Synchronisers: first stage feeds only the second
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sy_slow_q <= 3'h0;
            sy_fast_q <= 3'h0;
            sy_ext_q  <= 3'h0;
            sy_rx_q   <= 2'h3;       // Idle line is high
        end else if (ce) begin
            sy_slow_q <= {sy_slow_q[1:0], slow_clk_tick};
            sy_fast_q <= {sy_fast_q[1:0], fast_internal_clock};
            sy_ext_q  <= {sy_ext_q[1:0], ext_baud_clk};
            sy_rx_q   <= {sy_rx_q[0], rx_pin};
        end
    end

    // ------------------------------------------------------------
    // Baud divider: counts source edges down to one 16x tick
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dcnt_q <= 15'h0000;
        end else if (ce && src_edge) begin
            if (tick) begin
                dcnt_q <= divisor;
            end else begin
                dcnt_q <= dcnt_q - 15'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes and transmit engine
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            thr_q     <= `UARB_RST_BYTE;
            div_lo_q  <= `UARB_RST_BYTE;
            div_hi_q  <= `UARB_RST_BYTE;
            ier_q     <= `UARB_RST_BYTE;
            fcr_q     <= `UARB_RST_BYTE;
            lcr_q     <= `UARB_RST_BYTE;
            mcr_q     <= `UARB_RST_BYTE;
            scr_q     <= `UARB_RST_BYTE;
            thr_empty <= 1'b1;
            tsr_q     <= `UARB_RST_BYTE;
            tbit_q    <= 4'h0;
            tsub_q    <= 4'h0;
            tbusy_q   <= 1'b0;
            tx_pin    <= 1'b1;
        end else if (ce) begin
            // Loading the shifter frees the holding buffer; a write in that cycle wins
            if (!tbusy_q && !thr_empty) begin
                tsr_q     <= thr_q;
                tbusy_q   <= 1'b1;
                tbit_q    <= 4'h0;
                tsub_q    <= 4'h0;
                thr_empty <= 1'b1;
                tx_pin    <= 1'b0;   // Start bit
            end else if (tbusy_q && tick) begin
                if (tsub_q == `UARB_OVERSAMPLE) begin
                    tsub_q <= 4'h0;
                    if (tbit_q == 4'h9) begin
                        tbusy_q <= 1'b0; // Stop bit done, byte complete
                    end else begin
                        tbit_q <= tbit_q + 4'h1;
                        if (tbit_q == 4'h8) begin
                            tx_pin <= 1'b1; // Stop bit
                        end else begin
                            tx_pin <= tsr_q[0];
                            tsr_q  <= {1'b0, tsr_q[7:1]};
                        end
                    end
                end else begin
                    tsub_q <= tsub_q + 4'h1;
                end
            end
            if (acc && wr) begin
                case (ofs)
                    `UARB_OFS_DATA: begin
                        if (divisor_latch_select) begin
                            div_lo_q <= wd;
                        end else begin
                            thr_q     <= wd;
                            thr_empty <= 1'b0;
                        end
                    end
                    `UARB_OFS_IER_DIVHI: begin
                        if (divisor_latch_select) begin
                            div_hi_q <= wd;
                        end else begin
                            ier_q <= {4'h0, wd[3:0]};
                        end
                    end
                    `UARB_OFS_FIFO_IID:  fcr_q <= {wd[7:6], 2'b00, wd[3], 3'b000};
                    `UARB_OFS_LINE_CTL:  lcr_q <= wd;
                    `UARB_OFS_MODEM_CTL: mcr_q <= wd;
                    `UARB_OFS_SCRATCH:   scr_q <= wd;
                    default: ;       // Status locations ignore writes
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Receive engine and read path
    // ------------------------------------------------------------
    wire rbr_read = acc && !wr && (ofs == `UARB_OFS_DATA) && !divisor_latch_select;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rbr_q    <= `UARB_RST_BYTE;
            rsr_q    <= `UARB_RST_BYTE;
            rbit_q   <= 4'h0;
            rsub_q   <= 4'h0;
            rbusy_q  <= 1'b0;
            rx_ready <= 1'b0;
            rdata    <= `UARB_RST_BYTE;
            rvalid   <= 1'b0;
        end else if (ce) begin
            rvalid <= acc && !wr;
            if (rbr_read) begin
                rx_ready <= 1'b0;
            end
            if (!rbusy_q) begin
                if (tick && !rx_s) begin
                    rbusy_q <= 1'b1; // Low line seen on a tick, start bit
                    rsub_q  <= 4'h0;
                    rbit_q  <= 4'h0;
                end
            end else if (tick) begin
                rsub_q <= rsub_q + 4'h1;
                if (rsub_q == `UARB_MID_SAMPLE) begin
                    if (rbit_q == 4'h0 && rx_s) begin
                        rbusy_q <= 1'b0; // Glitch, not a start bit
                    end else if (rbit_q == 4'h9) begin
                        rbusy_q  <= 1'b0;
                        rbr_q    <= rsr_q;
                        rx_ready <= 1'b1;    // New byte wins over a same-cycle read
                    end else if (rbit_q != 4'h0) begin
                        rsr_q <= {rx_s, rsr_q[7:1]};
                    end
                    if (rbit_q != 4'h9) begin
                        rbit_q <= rbit_q + 4'h1;
                    end
                end
            end
            if (acc && !wr) begin
                case (ofs)
                    `UARB_OFS_DATA:       rdata <= divisor_latch_select ? div_lo_q : rbr_q;
                    `UARB_OFS_IER_DIVHI:  rdata <= divisor_latch_select ? div_hi_q : ier_q;
                    `UARB_OFS_FIFO_IID:   rdata <= `UARB_RST_IID;
                    `UARB_OFS_LINE_CTL:   rdata <= lcr_q;
                    `UARB_OFS_MODEM_CTL:  rdata <= mcr_q;
                    `UARB_OFS_LINE_STAT:  rdata <= {1'b0, thr_empty & ~tbusy_q, thr_empty, 4'h0, rx_ready};
                    `UARB_OFS_MODEM_STAT: rdata <= 8'h00;
                    `UARB_OFS_SCRATCH:    rdata <= scr_q;
                    default:              rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // uarb_core

//--- include/uarb_defines.vh
// Register offsets, field positions, reset values and timing counts of the serial port front end
`ifndef UARB_DEFINES_VH
`define UARB_DEFINES_VH

// Register offsets relative to either base
`define UARB_OFS_DATA       3'h0
`define UARB_OFS_IER_DIVHI  3'h1
`define UARB_OFS_FIFO_IID   3'h2
`define UARB_OFS_LINE_CTL   3'h3
`define UARB_OFS_MODEM_CTL  3'h4
`define UARB_OFS_LINE_STAT  3'h5
`define UARB_OFS_MODEM_STAT 3'h6
`define UARB_OFS_SCRATCH    3'h7

// Embedded controller base address of the register block
`define UARB_EC_BASE        32'h400F1C00
`define UARB_EC_MASK        32'hFFFFFFF8

// Field positions
`define UARB_DIVISOR_LATCH_SELECT_BIT       7
`define UARB_BAUD_SEL_BIT   7

// Reset values
`define UARB_RST_BYTE       8'h00
`define UARB_RST_IID        8'h01

// Baud timing: 16 ticks per bit
`define UARB_OVERSAMPLE     4'hF
`define UARB_MID_SAMPLE     4'h7

`endif

//--- sim/uarb_core_chk.sv
// Assertion checker for the serial port register front end
`timescale 1ns/1ps
`include "uarb_defines.vh"
module uarb_core_chk (
    input logic        clk,
    input logic        rst,
    input logic        ce,
    input logic        ec_sel,
    input logic        ec_wr,
    input logic [31:0] ec_addr,
    input logic [7:0]  ec_wdata,
    input logic        host_sel,
    input logic        host_wr,
    input logic [15:0] host_addr,
    input logic [15:0] host_bar,
    input logic [7:0]  host_wdata,
    input logic [7:0]  rdata,
    input logic        rvalid,
    input logic        tx_pin,
    input logic        rx_ready,
    input logic        thr_empty
);
    // ----------------------------------------
    // Taken access, controller wins a tie
    // ----------------------------------------
    wire       tk_ec = ce & ec_sel & (ec_addr[31:3] == 29'h0801E380);
    wire       tk_h  = ce & host_sel & (host_addr[15:3] == host_bar[15:3]) & ~tk_ec;
    wire       tk    = tk_ec | tk_h;
    wire       wr    = tk_ec ? ec_wr : host_wr;
    wire [2:0] ofs   = tk_ec ? ec_addr[2:0] : host_addr[2:0];
    wire [7:0] wd    = tk_ec ? ec_wdata : host_wdata;
    reg        divisor_latch_select_q;  // Shadow of the divisor latch select
    reg  [7:0] dlo_q;   // Shadow of divisor low byte
    reg  [7:0] dhi_q;   // Shadow of divisor high byte
    // Shadows follow taken writes only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            divisor_latch_select_q <= 1'b0;
            dlo_q  <= 8'h00;
            dhi_q  <= 8'h00;
        end else if (tk & wr) begin
            if (ofs == 3'h3) divisor_latch_select_q <= wd[`UARB_DIVISOR_LATCH_SELECT_BIT];
            if (ofs == 3'h0 && divisor_latch_select_q) dlo_q <= wd;
            if (ofs == 3'h1 && divisor_latch_select_q) dhi_q <= wd;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_ans; tk & ~wr |=> rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_refuse; ~tk |=> ~rvalid; endproperty
    a_refuse: assert property (p_refuse) else $error("spurious read answer");
    property p_iid; tk & ~wr & (ofs == 3'h2) |=> rdata == `UARB_RST_IID; endproperty
    a_iid: assert property (p_iid) else $error("ident read wrong");
    property p_div_lo; tk & ~wr & (ofs == 3'h0) & divisor_latch_select_q |=> rdata == $past(dlo_q); endproperty
    a_div_lo: assert property (p_div_lo) else $error("divisor low wrong");
    property p_div_hi; tk & ~wr & (ofs == 3'h1) & divisor_latch_select_q |=> rdata == $past(dhi_q); endproperty
    a_div_hi: assert property (p_div_hi) else $error("divisor high wrong");
    property p_thr; tk & wr & (ofs == 3'h0) & ~divisor_latch_select_q |=> ~thr_empty; endproperty
    a_thr: assert property (p_thr) else $error("holding buffer not filled");
    property p_load; $rose(thr_empty) |-> ~tx_pin; endproperty
    a_load: assert property (p_load) else $error("shifter load without start");
    property p_rx_clr; tk & ~wr & (ofs == 3'h0) & ~divisor_latch_select_q & rx_ready |=> ~rx_ready; endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("receive flag kept");
    property p_lsr; tk & ~wr & (ofs == 3'h5) |=> rdata[0] == $past(rx_ready) && rdata[5] == $past(thr_empty);
    endproperty
    a_lsr: assert property (p_lsr) else $error("status bits wrong");
    cover property (tk & ~wr & divisor_latch_select_q);
    cover property ($rose(rx_ready));
    cover property ($rose(thr_empty));
endmodule // uarb_core_chk
bind uarb_core uarb_core_chk chk_u (.clk(clk), .rst(rst), .ce(ce), .ec_sel(ec_sel), .ec_wr(ec_wr),
    .ec_addr(ec_addr), .ec_wdata(ec_wdata), .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr),
    .host_bar(host_bar), .host_wdata(host_wdata), .rdata(rdata), .rvalid(rvalid), .tx_pin(tx_pin),
    .rx_ready(rx_ready), .thr_empty(thr_empty));

//--- sim/uarb_core_tb_top.sv
// Self-checking bench for the serial port register front end
`timescale 1ns/1ps
`include "uarb_defines.vh"
module uarb_core_tb_top;
    localparam [15:0] HBAR = 16'h03F8;
    reg        clk = 0, rst = 1, ec_sel = 0, ec_wr = 0, host_sel = 0, host_wr = 0, ext_sel = 0;
    reg        slow_clk = 0, fast_clk = 0, ext_clk = 0;
    reg [31:0] ec_addr = 0;
    reg [15:0] host_addr = 0;
    reg [7:0]  ec_wdata = 0, host_wdata = 0;
    wire [7:0] rdata;
    wire       rvalid, tx_pin, rx_pin, rx_ready, thr_empty;
    integer    n_errors = 0, tests_run = 0, cyc = 0;
    initial forever #2.5 clk = ~clk;
    initial forever #271.267 slow_clk = ~slow_clk;
    initial forever #20.833 fast_clk = ~fast_clk;
    initial forever #50 ext_clk = ~ext_clk;
    uarb_core dut_u (.clk(clk), .rst(rst), .ce(1'b1), .ec_sel(ec_sel), .ec_wr(ec_wr), .ec_addr(ec_addr),
        .ec_wdata(ec_wdata), .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr), .host_bar(HBAR),
        .host_wdata(host_wdata), .external_baud_source_select(ext_sel), .slow_clk_tick(slow_clk),
        .fast_internal_clock(fast_clk), .ext_baud_clk(ext_clk), .rx_pin(rx_pin), .rdata(rdata),
        .rvalid(rvalid), .tx_pin(tx_pin), .rx_ready(rx_ready), .thr_empty(thr_empty));
    uarb_remote peer_u (.rx_pin(rx_pin), .tx_pin(tx_pin));
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // One access; offset 8 lands outside the window and must stay silent
    task io(input h, input w, input [31:0] a, input [7:0] d);
        begin
            @(negedge clk);
            host_sel = h;
            ec_sel = ~h;
            host_wr = w;
            ec_wr = w;
            ec_addr = `UARB_EC_BASE + a;
            host_addr = HBAR + a[15:0];
            ec_wdata = d;
            host_wdata = d;
            @(negedge clk);
            host_sel = 0;
            ec_sel = 0;
            // The read answer stands for one cycle only, so look right after the taking edge
            if (!w && a < 8) chk("rdata", d, rdata);
            chk("rvalid", {7'h0, !w && a < 8}, {7'h0, rvalid});
        end
    endtask
    task print_verdict;
        begin
            if (n_errors == 0 && tests_run > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // Hang guard, about two and a half times the expected run
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 0;
        io(0, 0, 0, 8'h00);
        io(1, 0, 2, 8'h01);
        io(0, 0, 8, 8'h00);
        io(0, 1, 3, 8'h80);
        io(0, 0, 0, 8'h00);
        io(1, 0, 1, 8'h00);
        io(1, 1, 0, 8'hA5);
        io(0, 1, 1, 8'hFF);
        io(1, 0, 0, 8'hA5);
        io(0, 0, 1, 8'hFF);
        io(0, 1, 3, 8'h00);
        io(0, 1, 1, 8'h0B);
        io(1, 0, 1, 8'h0B);
        io(0, 1, 3, 8'h80);
        io(0, 0, 1, 8'hFF);
        // A large divisor may already sit in the baud counter; only reset clears it quickly
        @(negedge clk);
        rst = 1;
        @(negedge clk);
        rst = 0;
        io(0, 1, 3, 8'h80);
        io(0, 0, 0, 8'h00);
        io(1, 0, 1, 8'h00);
        io(0, 1, 0, 8'h01);
        io(0, 1, 1, 8'h80);
        io(0, 1, 3, 8'h00);
        io(0, 1, 0, 8'h35);
        io(0, 1, 0, 8'hCA);
        chk("thr_empty", 8'h00, {7'h0, thr_empty});
        wait (peer_u.n_got == 1);
        chk("tx byte", 8'h35, peer_u.got_q);
        wait (peer_u.n_got == 2);
        chk("tx byte", 8'hCA, peer_u.got_q);
        peer_u.send(8'h5C);
        chk("rx_ready", 8'h01, {7'h0, rx_ready});
        io(1, 0, 0, 8'h5C);
        chk("rx_ready", 8'h00, {7'h0, rx_ready});
        io(0, 0, 5, 8'h60);
        io(0, 1, 3, 8'h80);
        io(0, 1, 1, 8'h00);
        io(0, 1, 3, 8'h00);
        peer_u.bit_ns = 8680.3;
        io(0, 1, 0, 8'h96);
        wait (peer_u.n_got == 3);
        chk("slow byte", 8'h96, peer_u.got_q);
        @(negedge clk);
        ext_sel = 1;
        io(0, 1, 3, 8'h80);
        io(0, 1, 1, 8'h80);
        io(0, 1, 3, 8'h00);
        peer_u.bit_ns = 1600.0;
        io(0, 1, 0, 8'h3A);
        wait (peer_u.n_got == 4);
        chk("ext byte", 8'h3A, peer_u.got_q);
        print_verdict;
    end
endmodule // uarb_core_tb_top

//--- sim/uarb_remote.sv
// Remote serial device: sends frames and captures frames, 8N1
`timescale 1ns/1ps
module uarb_remote (
    output reg  rx_pin,
    input  wire tx_pin
);
    real        bit_ns = 666.7; // Bit time, set by the bench per baud source
    reg  [7:0]  got_q;          // Last byte captured
    integer     n_got = 0;      // Bytes captured so far
    integer     i;
    initial rx_pin = 1'b1;
    // Capture: sample mid-bit, first data bit is bit 0
    always @(negedge tx_pin) begin
        #(bit_ns * 1.5);
        for (i = 0; i < 8; i = i + 1) begin
            got_q[i] = tx_pin;
            #(bit_ns);
        end
        n_got = n_got + 1;
    end
    // Send one frame, least significant bit first, line idles high
    task send(input [7:0] b);
        integer k;
        begin
            rx_pin = 1'b0;
            #(bit_ns);
            for (k = 0; k < 8; k = k + 1) begin
                rx_pin = b[k];
                #(bit_ns);
            end
            rx_pin = 1'b1;
            #(bit_ns);
        end
    endtask
endmodule // uarb_remote
